//--- rtl/mbp_pkg.sv
// constants, field layout and the crc step shared by the parameter-access block
// assumes a 50 MHz clock and an 8n1 serial link at 9600 bit/s
// Function
// - parameter address is block*32 + parameter*4 + 0x8000; parameters count from zero
// - each parameter is two 16-bit words, one 32-bit value, most significant first
// - read uses code 03, quantity 2; reply is address, 03, 04, four bytes, crc
// - write uses code 10, address, quantity 2, count 04, four bytes msb first, crc
// - a good write is answered with address, 10, echoed start and quantity, crc
// - request carries device address, code, address high/low, quantity high/low
// - delay parameters hold unsigned millisecond counts; one second reads 1000
// - universal counter value up to 99999999 (05F5E0FF) is accepted
// - analog monitor parameters 0..3 sit at consecutive four-step addresses
// - scale factor reads back as the setting times 100
// - link runs 9600 bit/s, eight data bits, one stop bit, no parity
// - frames are separated and delimited by 50 ms of idle line
package mbp_pkg;

  // ---------------------------------------------------------------
  // clocking and link timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC_DEF = CLK_HZ / BAUD;
  localparam int GAP_MS = 50;
  localparam int GAP_CYC_DEF = (CLK_HZ / 1000) * GAP_MS;
  localparam int BIT_CW = 13;
  localparam int GAP_CW = 22;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;  // start, 8 data, stop

  // ---------------------------------------------------------------
  // parameter map
  // ---------------------------------------------------------------
  localparam logic [15:0] FIRST_FUNCTION_BLOCK = 16'h8000;
  localparam logic [15:0] MONITOR_FIELD_VALUE_ONE = 16'h80a0;
  localparam logic [15:0] MONITOR_FIELD_VALUE_TWO = 16'h80a4;
  localparam logic [15:0] MONITOR_SCALE_FACTOR = 16'h80a8;
  localparam logic [15:0] MONITOR_OFFSET_VALUE = 16'h80ac;
  localparam int IDX_LSB = 2;  // four addresses per parameter
  localparam int MEM_AW = 8;  // 256 parameters stored, blocks 0..31
  localparam logic [5:0] WIN_TOP = 6'h20;  // addr[15:10] of the stored window

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [7:0] NODE_ADDR_DEF = 8'h01;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] BYTE_CNT = 8'h04;
  localparam logic [15:0] QTY_PARAM = 16'h0002;
  localparam logic [3:0] LEN_RD = 4'h8;
  localparam logic [3:0] LEN_WR = 4'hd;
  localparam logic [3:0] RSP_DATA_RD = 4'h7;
  localparam logic [3:0] RSP_DATA_WR = 4'h6;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  typedef enum logic [1:0] {ST_RX, ST_WAIT, ST_TX} mbp_state_t;

  // one byte of reflected modbus crc-16
  function automatic logic [15:0] mbp_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

//--- rtl/mbp_mem_if.sv
// carrier between the frame engine and the parameter store
// assumes both ends run on the same clock and clock enable
`timescale 1ns/1ps
interface mbp_mem_if;
  import mbp_pkg::*;
  logic ce;
  logic we;
  logic [MEM_AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output ce, output we, output addr, output wdata, input rdata);
  modport mem (input ce, input we, input addr, input wdata, output rdata);
endinterface

//--- rtl/mbp_param_mem.sv
// single-port store of 32-bit function-block parameters
// assumes the controller holds addr steady one cycle before it samples rdata
`timescale 1ns/1ps
module mbp_param_mem
  import mbp_pkg::*;
(
  // clock
  input wire logic clk_i,
  // access port
  mbp_mem_if.mem bus
);

  logic [31:0] store [0:(1<<MEM_AW)-1];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // no reset: contents are whatever software last wrote; values kept raw
  always_ff @(posedge clk_i) begin
    if (bus.ce) begin
      if (bus.we) begin
        store[bus.addr] <= bus.wdata;
      end
      bus.rdata <= store[bus.addr];
    end
  end

endmodule // mbp_param_mem

//--- rtl/mbp_block_param.sv
// modbus rtu slave that reads and writes 32-bit function-block parameters
// assumes rx_i is asynchronous; tx_en_o steers an external line driver
`timescale 1ns/1ps
module mbp_block_param
  import mbp_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEF,
  parameter int GAP_CYC = GAP_CYC_DEF,
  parameter logic [7:0] NODE_ADDR = NODE_ADDR_DEF
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // serial link
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_en_o
);

  localparam logic [BIT_CW-1:0] BIT_LIM = BIT_CW'(BIT_CYC - 1);
  localparam logic [BIT_CW-1:0] HALF_LIM = BIT_CW'(BIT_CYC / 2 - 1);
  localparam logic [GAP_CW-1:0] GAP_LIM = GAP_CW'(GAP_CYC - 1);

  mbp_mem_if mif ();

  mbp_param_mem u_mem (
    .clk_i(clk_i),
    .bus(mif.mem)
  );

  mbp_state_t state_r, state_nxt;
  logic rx_s1_r, rx_s2_r;
  logic rx_busy_r, rx_stb_r;
  logic [BIT_CW-1:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic [GAP_CW-1:0] gap_cnt_r;
  logic [7:0] buf_r [0:12];
  logic [3:0] nbyte_r;
  logic [15:0] crc_r;
  logic wr_r;
  logic [31:0] data_r;
  logic [3:0] tx_idx_r;
  logic [15:0] tx_crc_r;
  logic tx_busy_r, tx_en_r;
  logic [9:0] tx_sh_r;
  logic [BIT_CW-1:0] tx_cnt_r;
  logic [3:0] tx_bit_r;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire logic [15:0] req_addr = {buf_r[2], buf_r[3]};
  wire logic [15:0] req_qty = {buf_r[4], buf_r[5]};
  wire logic gap_hit = (gap_cnt_r == GAP_LIM);
  wire logic rx_tick = (rx_cnt_r == '0);
  wire logic tx_tick = (tx_cnt_r == '0);
  // only aligned addresses inside the stored window are answered
  wire logic addr_ok = (req_addr[IDX_LSB-1:0] == '0) && (req_addr[15:10] == WIN_TOP);
  wire logic hdr_ok = (buf_r[0] == NODE_ADDR) && (req_qty == QTY_PARAM) && addr_ok;
  wire logic crc_ok = (crc_r == CRC_RESIDUE);
  wire logic is_rd = (nbyte_r == LEN_RD) && (buf_r[1] == FC_READ);
  wire logic is_wr = (nbyte_r == LEN_WR) && (buf_r[1] == FC_WRITE)
                     && (buf_r[6] == BYTE_CNT);
  wire logic req_good = (state_r == ST_RX) && hdr_ok && crc_ok && (is_rd || is_wr);

  // parameter index: block and parameter number fold into consecutive slots
  assign mif.ce = ce_i;
  assign mif.addr = req_addr[IDX_LSB+MEM_AW-1:IDX_LSB];
  assign mif.we = req_good && is_wr && ce_i;
  // the full 32-bit word is stored unchecked, so 05F5E0FF and scaled values pass
  assign mif.wdata = {buf_r[7], buf_r[8], buf_r[9], buf_r[10]};

  // ---------------------------------------------------------------
  // reply assembly
  // ---------------------------------------------------------------
  wire logic [55:0] rd_vec = {NODE_ADDR, FC_READ, BYTE_CNT, data_r};
  wire logic [55:0] wr_vec = {NODE_ADDR, FC_WRITE, buf_r[2], buf_r[3],
                              buf_r[4], buf_r[5], 8'h00};
  wire logic [55:0] sel_vec = (wr_r ? wr_vec : rd_vec) << {tx_idx_r, 3'b000};
  wire logic [3:0] n_data = wr_r ? RSP_DATA_WR : RSP_DATA_RD;
  wire logic tx_more = (tx_idx_r < n_data + 4'h2);
  wire logic [7:0] tx_byte = (tx_idx_r < n_data) ? sel_vec[55:48] :
                             (tx_idx_r == n_data) ? tx_crc_r[7:0] : tx_crc_r[15:8];
  // the next byte loads on the final stop-bit tick, so bytes run back to back
  wire logic tx_last = tx_busy_r && tx_tick && (tx_bit_r == UART_LAST_BIT);
  wire logic tx_load = (state_r == ST_TX) && (!tx_busy_r || tx_last) && tx_more;

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else if (ce_i) begin
      rx_s1_r <= rx_i;
      rx_s2_r <= rx_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // receiver, 8n1, sampled mid-bit
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_busy_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
    end else if (ce_i) begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        rx_busy_r <= !rx_s2_r;
        rx_cnt_r <= HALF_LIM;
        rx_bit_r <= '0;
      end else if (!rx_tick) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= BIT_LIM;
        rx_bit_r <= rx_bit_r + 1'b1;
        if (rx_bit_r == '0) begin
          rx_busy_r <= !rx_s2_r;  // glitch shorter than half a bit is dropped
        end else if (rx_bit_r == UART_LAST_BIT) begin
          rx_busy_r <= 1'b0;
          rx_stb_r <= rx_s2_r;  // no parity; bad stop bit loses the byte
        end else begin
          rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // idle-line timer: a quiet line ends a frame
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gap_cnt_r <= '0;
    end else if (ce_i) begin
      if (rx_busy_r || !rx_s2_r) begin
        gap_cnt_r <= '0;
      end else if (!gap_hit) begin
        gap_cnt_r <= gap_cnt_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // frame buffer with running crc
  // ---------------------------------------------------------------
  // bytes beyond the longest frame push the count past both frame lengths so no request is accepted
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      nbyte_r <= '0;
      crc_r <= CRC_INIT;
    end else if (ce_i) begin
      if (gap_hit) begin
        nbyte_r <= '0;
        crc_r <= CRC_INIT;
      end else if (rx_stb_r && state_r == ST_RX) begin
        if (nbyte_r <= LEN_WR) begin
          nbyte_r <= nbyte_r + 1'b1;
        end
        crc_r <= mbp_crc_byte(crc_r, rx_sh_r);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && rx_stb_r && state_r == ST_RX && nbyte_r < LEN_WR) begin
      buf_r[nbyte_r] <= rx_sh_r;
    end
  end

  // ---------------------------------------------------------------
  // control sequence
  // ---------------------------------------------------------------
  // the reply waits for a full idle gap, which also spaces it from the request
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RX: if (req_good) state_nxt = ST_WAIT;
      ST_WAIT: if (gap_hit) state_nxt = ST_TX;
      ST_TX: if (!tx_busy_r && !tx_more) state_nxt = ST_RX;
      default: state_nxt = ST_RX;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_RX;
      wr_r <= 1'b0;
      data_r <= '0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (req_good) begin
        wr_r <= is_wr;
      end
      if (state_r == ST_WAIT) begin
        data_r <= mif.rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmitter, 8n1, lsb first
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_idx_r <= '0;
      tx_crc_r <= CRC_INIT;
    end else if (ce_i) begin
      if (state_r != ST_TX) begin
        tx_idx_r <= '0;
        tx_crc_r <= CRC_INIT;
      end else if (tx_load) begin
        tx_idx_r <= tx_idx_r + 1'b1;
        if (tx_idx_r < n_data) begin
          tx_crc_r <= mbp_crc_byte(tx_crc_r, tx_byte);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_busy_r <= 1'b0;
      tx_en_r <= 1'b0;
      tx_sh_r <= '1;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
    end else if (ce_i) begin
      tx_en_r <= (state_r == ST_TX);
      if (tx_load) begin
        tx_busy_r <= 1'b1;
        tx_sh_r <= {1'b1, tx_byte, 1'b0};
        tx_cnt_r <= BIT_LIM;
        tx_bit_r <= '0;
      end else if (tx_busy_r && !tx_tick) begin
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end else if (tx_busy_r) begin
        tx_cnt_r <= BIT_LIM;
        tx_bit_r <= tx_bit_r + 1'b1;
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        tx_busy_r <= (tx_bit_r != UART_LAST_BIT);
      end
    end
  end

  assign tx_o = tx_sh_r[0];  // line idles high from reset
  assign tx_en_o = tx_en_r;

endmodule // mbp_block_param

//--- sim/mbp_monitor.sv
// checker on the serial pins of the parameter block
// assumes one clock, clk_i, and a synchronous low reset
`timescale 1ns/1ps
module mbp_monitor #(
  parameter int BIT_CYC = 16,
  parameter int GAP_CYC = 400
) (
  // pins
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic rx_i,
  input wire logic tx_o,
  input wire logic tx_en_o
);
  // ----
  // helpers
  // ----
  int idle_r, run_r, en_r;
  // idle run of rx, level run of tx, reply length
  always_ff @(posedge clk_i) begin
    idle_r <= rx_i ? idle_r + 1 : 0;
    run_r <= (tx_o != $past(tx_o)) ? 1 : run_r + 1;
    en_r <= tx_en_o ? en_r + 1 : 0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----
  // pin checks
  // ----
  chk_reset_quiet: assert property (disable iff (1'b0) !nrst_i && ce_i |=> tx_o && !tx_en_o)
    else $error("tx not quiet after reset");
  chk_idle_high: assert property (!tx_en_o |-> tx_o)
    else $error("tx low while driver off");
  chk_start_low: assert property ($rose(tx_en_o) |-> ##[0:2] !tx_o)
    else $error("no start bit at reply start");
  chk_bit_width: assert property (tx_en_o && $past(tx_en_o) && en_r > 4 && tx_o != $past(tx_o)
    |-> run_r % BIT_CYC == 0)
    else $error("bit edge off the bit grid");
  chk_gap_first: assert property ($rose(tx_en_o) |-> idle_r >= GAP_CYC)
    else $error("reply before idle gap");
  chk_reply_len: assert property ($fell(tx_en_o) |-> (en_r >= 80*BIT_CYC-3 && en_r <= 80*BIT_CYC+3)
    || (en_r >= 90*BIT_CYC-3 && en_r <= 90*BIT_CYC+3))
    else $error("reply length not 8 or 9 bytes");
  chk_reply_hold: assert property ($rose(tx_en_o) |=> tx_en_o [*8])
    else $error("driver enable glitch");
  chk_stop_high: assert property ($fell(tx_en_o) |-> run_r >= BIT_CYC - 1)
    else $error("last stop bit cut short");
  chk_ce_freeze: assert property (!ce_i |=> $stable(tx_o) && $stable(tx_en_o))
    else $error("pins moved with clock enable low");
endmodule // mbp_monitor
bind mbp_block_param mbp_monitor #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) u_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .rx_i(rx_i), .tx_o(tx_o), .tx_en_o(tx_en_o));

//--- sim/mbp_master.sv
// behavioural bus master driving the slave's serial input
// assumes callers enter its tasks 2 ns after a rising edge
`timescale 1ns/1ps
module mbp_master #(
  parameter int BIT_CYC = 16,
  parameter int GAP_CYC = 400
) (
  // clock and line
  input wire logic clk_i,
  input wire logic tx_line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // reflected crc, init ffff
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // 8n1, lsb first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o = f[i];
      repeat (BIT_CYC) @(posedge clk_i);
      #2;
    end
  endtask
  // idle gap first so frames never merge; bad flips a crc bit
  task automatic send_frame(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    repeat (GAP_CYC + 4) @(posedge clk_i);
    #2;
    foreach (q[i]) send_byte(q[i]);
    send_byte(c[7:0]);
    send_byte(c[15:8]);
  endtask
  // bounded hunt for a start bit, then mid-bit samples
  task automatic recv_byte(input int lim, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    while (tx_line_i !== 1'b0 && n < lim) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    ok = n < lim;
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      if (i < 8) b[i] = tx_line_i;
    end
    #2;
  endtask
endmodule // mbp_master

//--- sim/tb_top.sv
// self-checking bench for the parameter block over its serial pins
// assumes the master model and the bound checker are compiled first
`timescale 1ns/1ps
module tb_top;
  import mbp_pkg::*;
  localparam int B = 16;
  localparam int G = 400;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic rx_w, tx_w, en_w;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] mdl [int];
  logic [31:0] seed = 32'h0db4;
  logic [31:0] t;
  mbp_block_param #(.BIT_CYC(B), .GAP_CYC(G), .NODE_ADDR(NODE_ADDR_DEF)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .rx_i(rx_w), .tx_o(tx_w), .tx_en_o(en_w));
  mbp_master #(.BIT_CYC(B), .GAP_CYC(G)) u_host (
    .clk_i(clk_i), .tx_line_i(tx_w), .line_o(rx_w));
  // 50 mhz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one exchange; the model decides if a reply is due and what it holds
  task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [31:0] v,
                      input bit bad);
    logic [7:0] q[$], r[$], b;
    logic [15:0] c;
    bit ok, acc, seen;
    q = {NODE_ADDR_DEF, fc, a[15:8], a[7:0], 8'h00, 8'h02};
    if (fc == FC_WRITE) q = {q, BYTE_CNT, v[31:24], v[23:16], v[15:8], v[7:0]};
    acc = !bad && a[15:10] == 6'h20 && a[1:0] == 2'b00;
    if (fc == FC_WRITE) r = q[0:5];
    else if (acc) r = {q[0], FC_READ, BYTE_CNT, mdl[a][31:24], mdl[a][23:16], mdl[a][15:8],
                       mdl[a][7:0]};
    if (acc && fc == FC_WRITE) mdl[a] = v;
    c = u_host.crc16(r);
    r = {r, c[7:0], c[15:8]};
    u_host.send_frame(q, bad);
    seen = 1'b0;
    if (!acc) begin
      for (int i = 0; i < 3 * G; i++) begin
        seen |= en_w;
        cyc(1);
      end
      check("silent reply", 0, seen);
    end else foreach (r[i]) begin
      u_host.recv_byte(i == 0 ? 2 * G : 2 * B, b, ok);
      check("reply byte", {1'b1, r[i]}, {ok, b});
      if (!ok) wrap_up();
    end
    cyc(2 * B);
  endtask
  // main sequence
  initial begin
    cyc(2);
    nrst_i = 1'b1;
    xfer(FC_WRITE, FIRST_FUNCTION_BLOCK, 32'h0000_03e8, 0);
    xfer(FC_READ, FIRST_FUNCTION_BLOCK, 0, 0);
    xfer(FC_WRITE, FIRST_FUNCTION_BLOCK, 32'h05f5_e0ff, 0);
    xfer(FC_WRITE, FIRST_FUNCTION_BLOCK, 32'h1234_5678, 1);
    xfer(FC_READ, FIRST_FUNCTION_BLOCK, 0, 0);
    xfer(FC_WRITE, 16'h8400, rnd(), 0);
    xfer(FC_READ, 16'h8002, 0, 0);
    for (int i = 0; i < 4; i++) xfer(FC_WRITE, 16'(MONITOR_FIELD_VALUE_ONE + 4 * i),
                                     i == 2 ? 32'h0000_0064 : rnd(), 0);
    for (int i = 0; i < 4; i++) xfer(FC_READ, 16'(MONITOR_FIELD_VALUE_ONE + 4 * i), 0, 0);
    ce_i = 1'b0;
    cyc(3);
    ce_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      t = rnd();
      t = {16'h0000, 16'h8000 + 16'(t[4:0]) * 16'h0020 + 16'(t[7:5]) * 16'h0004};
      xfer(FC_WRITE, t[15:0], rnd(), 0);
      xfer(FC_READ, t[15:0], 0, 0);
    end
    wrap_up();
  end
endmodule // tb_top
